//--- logic/warf_defs.vh
// constants for the watchdog and reset-cause flag block
`ifndef WARF_DEFS_VH
`define WARF_DEFS_VH

// register byte offsets on the axi4-lite port
`define WARF_OFF_CTRL 4'h0
`define WARF_OFF_FLAGS 4'h4
`define WARF_OFF_RESTART 4'h8

// watchdog_control field positions
`define WARF_CTRL_TOE 4
`define WARF_CTRL_EN 3
`define WARF_CTRL_SEL_HI 2
`define WARF_CTRL_SEL_LO 0
`define WARF_CTRL_RESET 8'h00

// reset_cause_flags field positions
`define WARF_FLG_SCAN 4
`define WARF_FLG_DOG 3
`define WARF_FLG_BOR 2
`define WARF_FLG_PIN 1
`define WARF_FLG_POR 0

// turn-off window in system clock cycles
`define WARF_TOE_CYCLES 3'h4

// shortest timeout in watchdog oscillator cycles
`define WARF_DOG_BASE 22'h004000
// default start-up length unit in system clock cycles
`define WARF_STARTUP_BASE 20'h00400

// axi response codes
`define WARF_RESP_OKAY 2'h0
`define WARF_RESP_SLVERR 2'h2

`endif

//--- logic/warf_top.v
// watchdog timer, chip reset stretcher, reset-cause flags and bandgap gating
//
// Contract
// - expiry gives one system clock reset pulse
// - pulse falling edge starts reset delay counter
// - clock-select fuses choose start-up timeout length
// - scan reset sets bit 4, cleared por/write0
// - watchdog reset sets bit 3, por/write0 clears
// - brown-out reset sets bit 2, por/write0 clears
// - pin reset sets bit 1, por/write0 clears
// - power-on sets bit 0, only write0 clears
// - bandgap on if brownout, comparator or converter
// - counter advances on watchdog oscillator cycles
// - counter zeroed by restart, disable, chip reset
// - expiry without restart resets the chip
// - control bits 7..5 read as zero
// - turn-off enable self-clears four cycles later
// - enable set by one, cleared only with toe
// - disable needs toe+en write, then en=0
// - period is 16384 shifted by select field
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "warf_defs.vh"

module warf_top #(
  parameter [21:0] DOG_BASE = `WARF_DOG_BASE,
  parameter [19:0] STARTUP_BASE = `WARF_STARTUP_BASE
) (
  input wire i_clk,
  input wire i_rst_n,
  // asynchronous reset sources, active high
  input wire i_poweron_rst,
  input wire i_brownout_rst,
  input wire i_pin_rst,
  input wire i_scan_rst,
  // free-running watchdog oscillator
  input wire i_wdt_osc,
  // static configuration and analog enables
  input wire [3:0] i_clock_select_fuses,
  input wire i_brownout_enable_fuse,
  input wire i_comparator_bandgap_select,
  input wire i_converter_enable,
  // axi4-lite slave
  input wire [3:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [3:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // block outputs
  output reg o_dog_reset,
  output reg o_chip_reset_n,
  output reg o_bandgap_en
);

  // address decode shared by the read and write paths
  function is_mapped;
    input [3:0] addr;
    begin
      is_mapped = (addr == `WARF_OFF_CTRL) || (addr == `WARF_OFF_FLAGS) || (addr == `WARF_OFF_RESTART);
    end
  endfunction

  // start-up length in system cycles from the fuses
  function [19:0] startup_len;
    input [3:0] fuses;
    begin
      startup_len = STARTUP_BASE << fuses[2:0];
    end
  endfunction

  // two-flop synchronisers for the four reset sources and the oscillator
  wire [4:0] async_in;
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  assign async_in = {i_wdt_osc, i_scan_rst, i_pin_rst, i_brownout_rst, i_poweron_rst};

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      // first stage feeds only the second stage
      always @(posedge i_clk) begin
        if (!i_rst_n) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= async_in[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  // synchronised copies by source
  wire por_s = sync2_r[0];
  wire bor_s = sync2_r[1];
  wire pin_s = sync2_r[2];
  wire scan_s = sync2_r[3];
  wire osc_s = sync2_r[4];

  // oscillator rising-edge detect on the synchronised copy
  reg osc_d_r;
  wire osc_tick;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= osc_s;
    end
  end
  assign osc_tick = osc_s & ~osc_d_r;

  // bus handshake terms
  wire aw_hs = i_awvalid & o_awready;
  wire w_hs = i_wvalid & o_wready;
  wire b_hs = o_bvalid & i_bready;
  wire ar_hs = i_arvalid & o_arready;
  wire r_hs = o_rvalid & i_rready;

  // write address and data are latched independently, either order
  reg aw_full_r;
  reg w_full_r;
  reg [3:0] aw_addr_r;
  reg [7:0] w_data_r;
  reg w_lane0_r;
  wire wr_fire;
  assign wr_fire = aw_full_r & w_full_r & ~o_bvalid;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `WARF_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (w_hs) begin
        w_full_r <= 1'b1;
        w_data_r <= i_wdata[7:0];
        w_lane0_r <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= is_mapped(aw_addr_r) ? `WARF_RESP_OKAY : `WARF_RESP_SLVERR;
      end
      // ready returns only after the response is taken
      if (b_hs) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // decoded write strobes; byte lane 0 carries all live bits
  wire wr_ctrl = wr_fire & w_lane0_r & (aw_addr_r == `WARF_OFF_CTRL);
  wire wr_flags = wr_fire & w_lane0_r & (aw_addr_r == `WARF_OFF_FLAGS);
  wire wr_restart = wr_fire & (aw_addr_r == `WARF_OFF_RESTART);

  // chip reset is any source, a watchdog pulse, or the stretcher running
  wire src_active;
  reg [19:0] delay_cnt_r;
  assign src_active = por_s | bor_s | pin_s | scan_s | o_dog_reset;

  // stretcher restarts while any source is high, so counting begins
  // on the cycle after the watchdog pulse falls
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      delay_cnt_r <= 20'h00000;
      o_chip_reset_n <= 1'b0;
    end else if (src_active) begin
      delay_cnt_r <= 20'h00000;
      o_chip_reset_n <= 1'b0;
    end else if (!o_chip_reset_n) begin
      if (delay_cnt_r == startup_len(i_clock_select_fuses) - 20'h00001) begin
        o_chip_reset_n <= 1'b1;
      end else begin
        delay_cnt_r <= delay_cnt_r + 20'h00001;
      end
    end
  end

  // watchdog control: enable, turn-off enable, period select
  reg dog_en_r;
  reg toe_r;
  reg [2:0] toe_cnt_r;
  reg [2:0] sel_r;
  wire chip_in_reset;
  assign chip_in_reset = ~o_chip_reset_n;

  // toe window counts system cycles; a later toe write restarts it
  always @(posedge i_clk) begin
    if (!i_rst_n || chip_in_reset) begin
      dog_en_r <= 1'b0;
      toe_r <= 1'b0;
      toe_cnt_r <= 3'h0;
      sel_r <= 3'h0;
    end else if (wr_ctrl) begin
      sel_r <= w_data_r[`WARF_CTRL_SEL_HI:`WARF_CTRL_SEL_LO];
      // clearing the enable looks at toe as it stood before this write
      if (w_data_r[`WARF_CTRL_EN]) begin
        dog_en_r <= 1'b1;
      end else if (toe_r) begin
        dog_en_r <= 1'b0;
      end
      toe_r <= w_data_r[`WARF_CTRL_TOE];
      toe_cnt_r <= w_data_r[`WARF_CTRL_TOE] ? `WARF_TOE_CYCLES : 3'h0;
    end else if (toe_r) begin
      if (toe_cnt_r == 3'h1) begin
        toe_r <= 1'b0;
        toe_cnt_r <= 3'h0;
      end else begin
        toe_cnt_r <= toe_cnt_r - 3'h1;
      end
    end
  end

  // watchdog counter in oscillator cycles
  reg [21:0] dog_cnt_r;
  wire [21:0] period;
  wire expire;
  assign period = DOG_BASE << sel_r;
  assign expire = dog_en_r & osc_tick & (dog_cnt_r == period - 22'h000001);

  // restart is acted on in the system domain, so no request is lost
  // between oscillator edges
  always @(posedge i_clk) begin
    if (!i_rst_n || chip_in_reset || !dog_en_r || wr_restart) begin
      dog_cnt_r <= 22'h000000;
    end else if (expire) begin
      dog_cnt_r <= 22'h000000;
    end else if (osc_tick) begin
      dog_cnt_r <= dog_cnt_r + 22'h000001;
    end
  end

  // single-cycle pulse; the stretcher then holds the chip in reset
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_dog_reset <= 1'b0;
    end else begin
      o_dog_reset <= expire;
    end
  end

  // reset-cause flags; i_rst_n acts as the power-on level for these,
  // the chip reset above never touches them
  reg scan_flag_r;
  reg dog_flag_r;
  reg bor_flag_r;
  reg pin_flag_r;
  reg por_flag_r;

  // set beats a software clear in the same cycle
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      scan_flag_r <= 1'b0;
      dog_flag_r <= 1'b0;
      bor_flag_r <= 1'b0;
      pin_flag_r <= 1'b0;
      por_flag_r <= 1'b1;
    end else begin
      if (por_s) begin
        scan_flag_r <= 1'b0;
        dog_flag_r <= 1'b0;
        bor_flag_r <= 1'b0;
        pin_flag_r <= 1'b0;
      end else begin
        if (scan_s) begin
          scan_flag_r <= 1'b1;
        end else if (wr_flags && !w_data_r[`WARF_FLG_SCAN]) begin
          scan_flag_r <= 1'b0;
        end
        if (o_dog_reset) begin
          dog_flag_r <= 1'b1;
        end else if (wr_flags && !w_data_r[`WARF_FLG_DOG]) begin
          dog_flag_r <= 1'b0;
        end
        if (bor_s) begin
          bor_flag_r <= 1'b1;
        end else if (wr_flags && !w_data_r[`WARF_FLG_BOR]) begin
          bor_flag_r <= 1'b0;
        end
        if (pin_s) begin
          pin_flag_r <= 1'b1;
        end else if (wr_flags && !w_data_r[`WARF_FLG_PIN]) begin
          pin_flag_r <= 1'b0;
        end
      end
      // only a software zero clears the power-on flag
      if (por_s) begin
        por_flag_r <= 1'b1;
      end else if (wr_flags && !w_data_r[`WARF_FLG_POR]) begin
        por_flag_r <= 1'b0;
      end
    end
  end

  // read data assembly; upper bits and reserved bits read zero
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    case (i_araddr)
      `WARF_OFF_CTRL: rd_word = {24'h000000, 3'h0, toe_r, dog_en_r, sel_r};
      `WARF_OFF_FLAGS: rd_word = {24'h000000, 3'h0, scan_flag_r, dog_flag_r, bor_flag_r, pin_flag_r, por_flag_r};
      default: rd_word = 32'h00000000;
    endcase
  end

  // read channel: one outstanding read, answer one cycle after address
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `WARF_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= is_mapped(i_araddr) ? `WARF_RESP_OKAY : `WARF_RESP_SLVERR;
      end else if (r_hs) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // reference gating; software still owns the start-up wait
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bandgap_en <= 1'b0;
    end else begin
      o_bandgap_en <= i_brownout_enable_fuse | i_comparator_bandgap_select | i_converter_enable;
    end
  end

endmodule

//--- dv/warf_chk_sva.sv
// port-level assertions for the watchdog and reset-flag block
`timescale 1ns/1ps
module warf_chk #(
  parameter [21:0] DOG_BASE = 22'h8,
  parameter [19:0] STARTUP_BASE = 20'h4
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_brownout_enable_fuse,
  input wire i_comparator_bandgap_select,
  input wire i_converter_enable,
  input wire i_awvalid,
  input wire i_wvalid,
  input wire i_arvalid,
  input wire o_awready,
  input wire o_wready,
  input wire o_bvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire o_dog_reset,
  input wire o_chip_reset_n,
  input wire o_bandgap_en,
  input wire [31:0] o_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // address and data taken at one edge
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  // chip stays in reset for the first three cycles of the start-up count
  sequence s_held_low;
    !o_chip_reset_n [*3];
  endsequence
  AST_DOG_ONE: assert property (o_dog_reset |=> !o_dog_reset)
    else $error("dog pulse longer than one cycle");
  AST_DOG_CHIP: assert property (o_dog_reset |=> s_held_low)
    else $error("dog pulse did not hold chip reset");
  // bandgap gate lags its enables by one cycle
  AST_BGAP: assert property ($past(i_rst_n) |->
    o_bandgap_en == $past(i_brownout_enable_fuse || i_comparator_bandgap_select || i_converter_enable))
    else $error("bandgap enable wrong");
  AST_BLAT: assert property (s_wr_take |-> ##[1:2] o_bvalid)
    else $error("write response late");
  AST_RLAT: assert property (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
    else $error("read response late");
  AST_WBUSY: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  AST_RBUSY: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");
  AST_UPPER: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule
bind warf_top warf_chk #(
  .DOG_BASE(DOG_BASE),
  .STARTUP_BASE(STARTUP_BASE)
) warf_chk_i (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_brownout_enable_fuse(i_brownout_enable_fuse),
  .i_comparator_bandgap_select(i_comparator_bandgap_select),
  .i_converter_enable(i_converter_enable),
  .i_awvalid(i_awvalid),
  .i_wvalid(i_wvalid),
  .i_arvalid(i_arvalid),
  .o_awready(o_awready),
  .o_wready(o_wready),
  .o_bvalid(o_bvalid),
  .o_arready(o_arready),
  .o_rvalid(o_rvalid),
  .o_dog_reset(o_dog_reset),
  .o_chip_reset_n(o_chip_reset_n),
  .o_bandgap_en(o_bandgap_en),
  .o_rdata(o_rdata)
);

//--- dv/warf_top_bench.sv
// self-checking bench for the watchdog and reset-flag block
`timescale 1ns/1ps
`include "warf_defs.vh"
module warf_top_bench;
  logic i_clk = 0, i_rst_n = 0, i_poweron_rst = 0, i_brownout_rst = 0, i_pin_rst = 0, i_scan_rst = 0;
  logic i_wdt_osc = 0, i_brownout_enable_fuse = 0, i_comparator_bandgap_select = 0, i_converter_enable = 0;
  logic i_awvalid = 0, i_wvalid = 0, i_arvalid = 0, i_bready = 1, i_rready = 1;
  logic [3:0] i_clock_select_fuses = 4'h1, i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] rv;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dog_reset, o_chip_reset_n, o_bandgap_en;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  integer fails = 0, n_compared = 0, n_dog = 0, cyc = 0;
  // small counts keep the run short
  localparam [21:0] DB = 22'h000008;
  localparam [19:0] SB = 20'h00004;
  warf_top #(
    .DOG_BASE(DB),
    .STARTUP_BASE(SB)
  ) warf_top_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_poweron_rst(i_poweron_rst),
    .i_brownout_rst(i_brownout_rst),
    .i_pin_rst(i_pin_rst),
    .i_scan_rst(i_scan_rst),
    .i_wdt_osc(i_wdt_osc),
    .i_clock_select_fuses(i_clock_select_fuses),
    .i_brownout_enable_fuse(i_brownout_enable_fuse),
    .i_comparator_bandgap_select(i_comparator_bandgap_select),
    .i_converter_enable(i_converter_enable),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_dog_reset(o_dog_reset),
    .o_chip_reset_n(o_chip_reset_n),
    .o_bandgap_en(o_bandgap_en)
  );
  always #2 i_clk = ~i_clk;
  // oscillator at an eighth of the clock, moved on the rising edge
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) i_wdt_osc <= ~i_wdt_osc;
    if (o_dog_reset === 1'b1) n_dog <= n_dog + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // write: offer address and data together, drop each when taken
  task wr(input [3:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
      n = 0;
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      while (n < 100) begin
        @(posedge i_clk);
        n = n + 1;
        if (i_awvalid && o_awready) i_awvalid <= 1'b0;
        if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        if (o_bvalid === 1'b1) n = 200;
      end
      chk(n == 200 ? o_bresp : 32'hdead, er);
    end
  endtask
  task rd(input [3:0] a, input [1:0] er);
    integer n;
    begin
      n = 0;
      i_araddr <= a;
      i_arvalid <= 1'b1;
      while (n < 100) begin
        @(posedge i_clk);
        n = n + 1;
        if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        if (o_rvalid === 1'b1) n = 200;
      end
      rv = o_rdata;
      chk(n == 200 ? o_rresp : 32'hdead, er);
    end
  endtask
  // bounded wait for the chip to leave reset
  task wait_chip;
    integer n;
    begin
      n = 0;
      while (o_chip_reset_n !== 1'b1 && n < 300) begin
        @(posedge i_clk);
        n = n + 1;
      end
      chk(o_chip_reset_n, 1'b1);
    end
  endtask
  task t_regs;
    begin
      wait_chip;
      rd(`WARF_OFF_CTRL, 2'h0);
      chk(rv, 32'h0);
      rd(`WARF_OFF_FLAGS, 2'h0);
      chk(rv, 32'h1);
      wr(`WARF_OFF_CTRL, 32'he0, 2'h0);
      rd(`WARF_OFF_CTRL, 2'h0);
      chk(rv, 32'h0);
      wr(4'hc, 32'h0, 2'h2);
      rd(4'hc, 2'h2);
      chk(rv, 32'h0);
    end
  endtask
  // each outside source sets its own flag; power-on clears the rest
  task t_flags;
    integer k;
    begin
      wr(`WARF_OFF_FLAGS, 32'h0, 2'h0);
      rd(`WARF_OFF_FLAGS, 2'h0);
      chk(rv, 32'h0);
      for (k = 1; k < 5; k = k * 2) begin
        {i_scan_rst, i_brownout_rst, i_pin_rst} <= {k == 4, k == 2, k == 1};
        repeat (4) @(posedge i_clk);
        {i_scan_rst, i_brownout_rst, i_pin_rst} <= 3'h0;
        repeat (3) @(posedge i_clk);
        wait_chip;
        rd(`WARF_OFF_FLAGS, 2'h0);
        chk(rv, 32'h1 << k);
        wr(`WARF_OFF_FLAGS, 32'h0, 2'h0);
      end
      i_pin_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_pin_rst <= 1'b0;
      i_poweron_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_poweron_rst <= 1'b0;
      repeat (3) @(posedge i_clk);
      wait_chip;
      rd(`WARF_OFF_FLAGS, 2'h0);
      chk(rv, 32'h1);
    end
  endtask
  task t_bgap;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        {i_brownout_enable_fuse, i_comparator_bandgap_select, i_converter_enable} <= k[2:0];
        repeat (3) @(posedge i_clk);
        chk(o_bandgap_en, k != 0);
      end
    end
  endtask
  // select 1 doubles the base period: 16 ticks of 8 cycles
  task t_dog;
    integer t0, n;
    begin
      wr(`WARF_OFF_FLAGS, 32'h0, 2'h0);
      // a longer start-up choice than the default fuses
      i_clock_select_fuses <= 4'h2;
      wr(`WARF_OFF_CTRL, 32'h9, 2'h0);
      t0 = cyc;
      n = 0;
      while (o_dog_reset !== 1'b1 && n < 2000) begin
        @(posedge i_clk);
        n = n + 1;
      end
      chk(cyc - t0 >= 100 && cyc - t0 <= 150, 1'b1);
      @(posedge i_clk);
      chk(o_dog_reset, 1'b0);
      // stretch counted from the edge after the pulse falls
      n = 0;
      while (o_chip_reset_n !== 1'b1 && n < 300) begin
        @(posedge i_clk);
        n = n + 1;
      end
      chk(n, SB << 2);
      rd(`WARF_OFF_FLAGS, 2'h0);
      chk(rv, 32'h8);
      rd(`WARF_OFF_CTRL, 2'h0);
      chk(rv, 32'h0);
    end
  endtask
  task t_restart;
    integer k, d;
    begin
      d = n_dog;
      wr(`WARF_OFF_CTRL, 32'h9, 2'h0);
      for (k = 0; k < 6; k = k + 1) begin
        repeat (80) @(posedge i_clk);
        wr(`WARF_OFF_RESTART, 32'h0, 2'h0);
      end
      chk(n_dog, d);
      wr(`WARF_OFF_CTRL, 32'h1, 2'h0);
      rd(`WARF_OFF_CTRL, 2'h0);
      chk(rv, 32'h9);
      wr(`WARF_OFF_CTRL, 32'h19, 2'h0);
      repeat (8) @(posedge i_clk);
      wr(`WARF_OFF_CTRL, 32'h1, 2'h0);
      rd(`WARF_OFF_CTRL, 2'h0);
      chk(rv, 32'h9);
      wr(`WARF_OFF_CTRL, 32'h19, 2'h0);
      wr(`WARF_OFF_CTRL, 32'h1, 2'h0);
      rd(`WARF_OFF_CTRL, 2'h0);
      chk(rv, 32'h1);
      repeat (300) @(posedge i_clk);
      chk(n_dog, d);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs;
    t_flags;
    t_bgap;
    t_dog;
    t_restart;
    tally_and_finish;
  end
  // hang guard well beyond the expected run of a little over a thousand cycles
  initial begin
    #100000;
    fails = fails + 1;
    tally_and_finish;
  end
endmodule
